// ---- hdl/cpu_register_set.sv ----
`timescale 1ns/10ps
// What this block does
// - 16-bit instruction pointer tracks fetched instruction
// - 16-bit accumulator; byte ops touch low byte
// - 16-bit second operand; byte ops use low byte
// - index, extra pointer and stack pointer, 16-bit
// - status word: bank pointer high, condition byte low
// - half carry from bit 3 into 4
// - interrupt enable gates interrupts, cleared by reset
// - level mask admits only higher-level requests
// - negative flag copies result MSB
// - zero flag set on zero result
// - overflow flag on two's complement overflow
// - carry flag on carry or borrow out of bit 7, bit 15 for 16-bit ops
// - shifts load carry with shifted-out bit
// - eight-bit registers, eight per bank, 32 banks
// - bank pointer selects active register bank
// - one 64-Kbyte space for all areas
// - I/O lowest, data above, program highest
module cpu_register_set (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        irqRequest,
    input  wire logic [1:0]  irqLevel,
    output logic             irqAccept
);
    import cpu_regs_pkg::*;

    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RDWAIT} phase_t;

    typedef struct packed {
        logic        h;
        logic        n;
        logic        z;
        logic        v;
        logic        c;
        logic [15:0] res;
    } alu_t;

    typedef struct packed {
        logic [15:0] ip;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] ix;
        logic [15:0] ep;
        logic [15:0] sp;
        logic [15:0] psw;
        logic [15:0] areaAddr;
        logic [2:0]  gprSel;
        phase_t      phase;
        logic [7:0]  capAddr;
        logic        capHit;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
        logic        irqAccept;
    } state_t;

    state_t      st;
    state_t      next_st;
    alu_t        aluOut;
    op_t         execOp;
    logic        execGo;
    logic        commit;
    logic        accept;
    logic        gprWrite;
    logic [7:0]  gprRead;
    logic [15:0] bankBase;
    logic [31:0] rdMux;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic        ovf8;
    logic        borrow8;

    // codes 00 and 01 both stand for the top level; smaller means higher
    function automatic logic [1:0] level_of(input logic [1:0] code);
        level_of = (code == 2'h0) ? 2'h1 : code;
    endfunction : level_of

    // which area of the 64-Kbyte space an address falls in
    function automatic logic [1:0] area_of(input logic [15:0] a);
        if (a <= IO_LAST) begin
            area_of = AREA_IO;
        end else if (a <= DATA_LAST) begin
            area_of = AREA_DATA;
        end else if (a >= PROG_FIRST) begin
            area_of = AREA_PROG;
        end else begin
            area_of = AREA_GAP;
        end
    endfunction : area_of

    // arithmetic step: acc op tmp, with condition flags
    function automatic alu_t alu_step(input op_t op, input logic [15:0] a,
                                      input logic [15:0] t, input logic [7:0] condition_byte);
        alu_t        r;
        logic [16:0] s;
        logic [4:0]  hs;
        logic        wide;
        r    = '0;
        s    = 17'h00000;
        hs   = 5'h00;
        wide = 1'b0;
        unique case (op)
            OP_ADD8: begin
                s     = {9'h000, a[7:0]} + {9'h000, t[7:0]};
                hs    = {1'b0, a[3:0]} + {1'b0, t[3:0]};
                r.res = {a[15:8], s[7:0]};
                r.c   = s[8];
                r.v   = (a[7] == t[7]) && (s[7] != a[7]);
            end
            OP_SUB8: begin
                s     = {9'h000, a[7:0]} - {9'h000, t[7:0]};
                hs    = {1'b0, a[3:0]} - {1'b0, t[3:0]};
                r.res = {a[15:8], s[7:0]};
                r.c   = s[8];
                r.v   = (a[7] != t[7]) && (s[7] != a[7]);
            end
            OP_ADD16: begin
                s     = {1'b0, a} + {1'b0, t};
                hs    = {1'b0, a[3:0]} + {1'b0, t[3:0]};
                r.res = s[15:0];
                r.c   = s[16];
                r.v   = (a[15] == t[15]) && (s[15] != a[15]);
                wide  = 1'b1;
            end
            OP_SUB16: begin
                s     = {1'b0, a} - {1'b0, t};
                hs    = {1'b0, a[3:0]} - {1'b0, t[3:0]};
                r.res = s[15:0];
                r.c   = s[16];
                r.v   = (a[15] != t[15]) && (s[15] != a[15]);
                wide  = 1'b1;
            end
            OP_SHL8: begin
                r.res = {a[15:8], a[6:0], 1'b0};
                r.c   = a[7];
                r.v   = condition_byte[PSW_V];
                hs    = {condition_byte[PSW_H], 4'h0};
            end
            OP_SHR8: begin
                r.res = {a[15:8], 1'b0, a[7:1]};
                r.c   = a[0];
                r.v   = condition_byte[PSW_V];
                hs    = {condition_byte[PSW_H], 4'h0};
            end
            default: begin
                r.res = a;
                r.c   = condition_byte[PSW_C];
                r.v   = condition_byte[PSW_V];
                hs    = {condition_byte[PSW_H], 4'h0};
            end
        endcase
        r.h = hs[4];
        r.n = wide ? r.res[15] : r.res[7];
        r.z = wide ? (r.res == 16'h0000) : (r.res[7:0] == 8'h00);
        return r;
    endfunction : alu_step

    // helpers for the flag checks below
    always_comb begin
        sum9 = {1'b0, st.acc[7:0]} + {1'b0, st.tmp[7:0]};
        nib5 = {1'b0, st.acc[3:0]} + {1'b0, st.tmp[3:0]};
        ovf8    = (st.acc[7] == st.tmp[7]) && (sum9[7] != st.acc[7]);
        borrow8 = st.acc[7:0] < st.tmp[7:0];
    end

    // read data is chosen in the wait cycle, after any prior write landed
    always_comb begin
        case (st.capAddr)
            OFF_IP:       rdMux = {16'h0000, st.ip};
            OFF_ACC:      rdMux = {16'h0000, st.acc};
            OFF_TMP:      rdMux = {16'h0000, st.tmp};
            OFF_IX:       rdMux = {16'h0000, st.ix};
            OFF_EP:       rdMux = {16'h0000, st.ep};
            OFF_SP:       rdMux = {16'h0000, st.sp};
            OFF_PSW:      rdMux = {16'h0000, st.psw};
            OFF_GPR_SEL:  rdMux = {29'h00000000, st.gprSel};
            OFF_GPR_DATA: rdMux = {24'h000000, gprRead};
            OFF_BANK:     rdMux = {16'h0000, bankBase};
            OFF_AREA:     rdMux = {14'h0000, area_of(st.areaAddr), st.areaAddr};
            default:      rdMux = 32'h00000000; // unmapped and write-only read as zero
        endcase
    end

    // next-state: register writes, execution, bus phases, interrupt gate
    always_comb begin
        next_st  = st;
        accept   = hsel && htrans[1] && hready;
        commit   = (st.phase == PH_WRITE) && st.capHit;
        execOp   = op_t'(hwdata[2:0]);
        execGo   = commit && (st.capAddr == OFF_EXEC) && (hwdata[2:0] < OP_LIMIT);
        gprWrite = commit && (st.capAddr == OFF_GPR_DATA);
        aluOut   = alu_step(execOp, st.acc, st.tmp, st.psw[7:0]);

        // write data phase: store into the addressed register
        if (commit) begin
            case (st.capAddr)
                OFF_IP:      next_st.ip       = hwdata[15:0];
                OFF_ACC:     next_st.acc      = hwdata[15:0];
                OFF_TMP:     next_st.tmp      = hwdata[15:0];
                OFF_IX:      next_st.ix       = hwdata[15:0];
                OFF_EP:      next_st.ep       = hwdata[15:0];
                OFF_SP:      next_st.sp       = hwdata[15:0];
                OFF_PSW:     next_st.psw      = hwdata[15:0];
                OFF_GPR_SEL: next_st.gprSel   = hwdata[2:0];
                OFF_AREA:    next_st.areaAddr = hwdata[15:0];
                default: begin
                end
            endcase
        end

        // one executed step updates result, flags and moves to the next fetch
        if (execGo) begin
            next_st.acc        = aluOut.res;
            next_st.psw[PSW_H] = aluOut.h;
            next_st.psw[PSW_N] = aluOut.n;
            next_st.psw[PSW_Z] = aluOut.z;
            next_st.psw[PSW_V] = aluOut.v;
            next_st.psw[PSW_C] = aluOut.c;
            next_st.ip         = st.ip + 16'h0001;
        end

        // bus: writes take no wait, reads take one so hrdata comes from a flop
        next_st.hresp = 1'b0;
        unique case (st.phase)
            PH_IDLE, PH_WRITE: begin
                next_st.phase     = PH_IDLE;
                next_st.hreadyout = 1'b1;
                if (accept) begin
                    next_st.capAddr   = haddr[7:0];
                    next_st.capHit    = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0)
                                        && (hsize == SIZE_WORD);
                    next_st.phase     = hwrite ? PH_WRITE : PH_RDWAIT;
                    next_st.hreadyout = hwrite;
                end
            end
            PH_RDWAIT: begin
                next_st.hrdata    = st.capHit ? rdMux : 32'h00000000;
                next_st.hreadyout = 1'b1;
                next_st.phase     = PH_IDLE;
            end
        endcase

        // admit a request only if enabled and strictly above the mask level
        next_st.irqAccept = irqRequest && st.psw[PSW_IE]
                            && (level_of(irqLevel) < level_of(st.psw[PSW_IL +: 2]));
    end

    // single state register; the enable bit comes up clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st           <= '0;
            st.ip        <= RST_PTR;
            st.acc       <= RST_PTR;
            st.tmp       <= RST_PTR;
            st.ix        <= RST_PTR;
            st.ep        <= RST_PTR;
            st.sp        <= RST_PTR;
            st.psw       <= RST_PSW;
            st.areaAddr  <= RST_PTR;
            st.phase     <= PH_IDLE;
            st.hreadyout <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    always_comb begin
        hreadyout = st.hreadyout;
        hrdata    = st.hrdata;
        hresp     = st.hresp;
        irqAccept = st.irqAccept;
    end

    // low five pointer bits pick one of 32 banks
    gpr_bank_store u_gpr (
        .clock    (clock),
        .rst_b    (rst_b),
        .bankPtr  (st.psw[PSW_BANK +: 5]),
        .regSel   (st.gprSel),
        .wrEn     (gprWrite),
        .wrData   (hwdata[7:0]),
        .rdData   (gprRead),
        .bankBase (bankBase)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    ie_reset_a: assert property ($rose(rst_b) |-> !st.psw[PSW_IE])
        else $error("interrupt enable not clear after reset");
    // carry, half carry and overflow are rebuilt here from the operands, N and Z from the result, so a slip in the step function shows up
    half_carry_a: assert property (execGo && execOp == OP_ADD8
        |=> st.psw[PSW_H] == $past(nib5[4])) else $error("half carry wrong");
    carry_add_a: assert property (execGo && execOp == OP_ADD8
        |=> st.psw[PSW_C] == $past(sum9[8])) else $error("carry out of bit 7 wrong");
    overflow_a: assert property (execGo && execOp == OP_ADD8
        |=> st.psw[PSW_V] == $past(ovf8)) else $error("overflow flag wrong");
    shift_carry_a: assert property (execGo && execOp == OP_SHR8
        |=> st.psw[PSW_C] == $past(st.acc[0])) else $error("shift carry wrong");
    shl_carry_a: assert property (execGo && execOp == OP_SHL8
        |=> st.psw[PSW_C] == $past(st.acc[7])) else $error("left shift carry wrong");
    sub_borrow_a: assert property (execGo && execOp == OP_SUB8
        |=> st.psw[PSW_C] == $past(borrow8)) else $error("borrow out of bit 7 wrong");
    zero_flag_a: assert property (execGo && execOp != OP_ADD16 && execOp != OP_SUB16
        |=> st.psw[PSW_Z] == (st.acc[7:0] == 8'h00)) else $error("zero flag wrong");
    neg_flag_a: assert property (execGo && (execOp == OP_ADD16 || execOp == OP_SUB16)
        |=> st.psw[PSW_N] == st.acc[15]) else $error("negative flag wrong");
    wide_zero_a: assert property (execGo && (execOp == OP_ADD16 || execOp == OP_SUB16)
        |=> st.psw[PSW_Z] == (st.acc == 16'h0000)) else $error("wide zero flag wrong");
    upper_keep_a: assert property (execGo && execOp != OP_ADD16 && execOp != OP_SUB16
        |=> st.acc[15:8] == $past(st.acc[15:8])) else $error("byte op touched upper byte");
    ip_step_a: assert property (execGo |=> st.ip == $past(st.ip) + 16'h0001)
        else $error("instruction pointer did not advance");
    mask_top_a: assert property ($past(st.psw[PSW_IL + 1]) == 1'b0 |-> !st.irqAccept)
        else $error("top mask level admitted a request");
    req_low_a: assert property ($past(irqLevel) == 2'h3 |-> !st.irqAccept)
        else $error("lowest level request admitted");
    ie_gate_a: assert property (st.irqAccept |-> $past(st.psw[PSW_IE]) && $past(irqRequest))
        else $error("request admitted while disabled");
    read_wait_a: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");

    // scenarios the bench must reach
    add8_c: cover property (execGo && execOp == OP_ADD8 ##1 st.psw[PSW_C]);
    shift_c: cover property (execGo && execOp == OP_SHL8);
    irq_c: cover property (st.irqAccept);
    read_c: cover property (accept && !hwrite ##2 hreadyout);
    sub16_c: cover property (execGo && execOp == OP_SUB16);

endmodule : cpu_register_set

// ---- hdl/cpu_regs_pkg.sv ----
package cpu_regs_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_IP       = 8'h00;
    localparam logic [7:0] OFF_ACC      = 8'h04;
    localparam logic [7:0] OFF_TMP      = 8'h08;
    localparam logic [7:0] OFF_IX       = 8'h0C;
    localparam logic [7:0] OFF_EP       = 8'h10;
    localparam logic [7:0] OFF_SP       = 8'h14;
    localparam logic [7:0] OFF_PSW      = 8'h18;
    localparam logic [7:0] OFF_EXEC     = 8'h1C;
    localparam logic [7:0] OFF_GPR_SEL  = 8'h20;
    localparam logic [7:0] OFF_GPR_DATA = 8'h24;
    localparam logic [7:0] OFF_BANK     = 8'h28;
    localparam logic [7:0] OFF_AREA     = 8'h2C;

    // status word fields: bank pointer in the upper byte, condition byte below
    localparam int PSW_H    = 7;
    localparam int PSW_IE   = 6;
    localparam int PSW_IL   = 4;
    localparam int PSW_N    = 3;
    localparam int PSW_Z    = 2;
    localparam int PSW_V    = 1;
    localparam int PSW_C    = 0;
    localparam int PSW_BANK = 8;

    // reset values
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [15:0] RST_PSW = 16'h0030;

    // memory map bounds and general-purpose register area
    localparam logic [15:0] IO_LAST       = 16'h007F;
    localparam logic [15:0] DATA_LAST     = 16'h0FFF;
    localparam logic [15:0] PROG_FIRST    = 16'h8000;
    localparam logic [15:0] REG_AREA_BASE = 16'h0100;

    localparam logic [1:0] AREA_IO   = 2'h0;
    localparam logic [1:0] AREA_DATA = 2'h1;
    localparam logic [1:0] AREA_PROG = 2'h2;
    localparam logic [1:0] AREA_GAP  = 2'h3;

    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [2:0] OP_LIMIT  = 3'h6;

    typedef enum logic [2:0] {
        OP_ADD8  = 3'h0,
        OP_SUB8  = 3'h1,
        OP_ADD16 = 3'h2,
        OP_SUB16 = 3'h3,
        OP_SHL8  = 3'h4,
        OP_SHR8  = 3'h5
    } op_t;

endpackage : cpu_regs_pkg

// ---- hdl/gpr_bank_store.sv ----
`timescale 1ns/10ps
module gpr_bank_store (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [4:0] bankPtr,
    input  wire logic [2:0] regSel,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    output logic     [15:0] bankBase
);
    import cpu_regs_pkg::*;

    // 32 banks of eight byte-wide registers; data is not cleared by reset
    logic [7:0] bankMem [0:255];

    // bank base: eight bytes per bank above the register area base
    always_comb begin
        bankBase = REG_AREA_BASE + {8'h00, bankPtr, 3'b000};
        rdData   = bankMem[{bankPtr, regSel}];
    end

    // synchronous write into the active bank
    always_ff @(posedge clock) begin
        if (wrEn) begin
            bankMem[{bankPtr, regSel}] <= wrData;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    gpr_echo_a: assert property ((wrEn ##1 ($stable(bankPtr) && $stable(regSel)))
        |-> rdData == $past(wrData)) else $error("register bank lost a write");
    bank_base_a: assert property (bankBase[2:0] == 3'h0
        && bankBase[15:8] == REG_AREA_BASE[15:8]) else $error("bank base off the 8-byte grid");

endmodule : gpr_bank_store

// ---- tb/cpu_register_set_and_flags_tb.sv ----
`timescale 1ns/10ps
module cpu_register_set_and_flags_tb;
    import cpu_regs_pkg::*;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        irqRequest = 1'b0;
    logic [1:0]  irqLevel = 2'h0;
    logic        hreadyout;
    logic        hresp;
    logic        irqAccept;
    logic [31:0] hrdata;
    logic [31:0] rdVal;
    logic [31:0] v;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          mAcc, mTmp, mPsw, mIp, pMask, e;
    int          gpr [32][8];
    int          banks [4] = '{0, 1, 31, 17};
    int          areas [8] = '{16'h0000, 16'h007F, 16'h0080, 16'h0FFF, 16'h1000, 16'h7FFF, 16'h8000, 16'hFFFF};
    int          tbl [11][3] = '{'{16'h000F, 16'h0001, 0}, '{16'h007F, 16'h0001, 0}, '{16'h00FF, 16'h0001, 0},
                                 '{16'h0000, 16'h0001, 1}, '{16'h0080, 16'h0001, 1}, '{16'h0010, 16'h0001, 1},
                                 '{16'hFFFF, 16'h0001, 2}, '{16'h0000, 16'h0001, 3}, '{16'h0081, 16'h0000, 4},
                                 '{16'h0001, 16'h0000, 5}, '{16'h1234, 16'h0001, 6}};

    // free running 100 MHz clock
    always #5 clock = ~clock;

    // single slave: its own ready is the bus ready
    cpu_register_set dut_u (
        .clock      (clock),
        .rst_b      (rst_b),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hreadyout  (hreadyout),
        .hrdata     (hrdata),
        .hresp      (hresp),
        .irqRequest (irqRequest),
        .irqLevel   (irqLevel),
        .irqAccept  (irqAccept)
    );

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // values read right after the edge are the pre-edge ones, so no race with the flops
    task wait_ready;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                end_of_test();
            end
            @(posedge clock);
        end
    endtask : wait_ready

    // one whole-word transfer; address phase held until taken, data phase until ready
    task xfer(input logic [7:0] off, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, off};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= SIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rdVal = hrdata;
    endtask : xfer

    task rdchk(input logic [7:0] off, input string nm, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
        xfer(off, 1'b0, 32'h0);
        check(nm, rdVal & m, exp & m);
        check({nm, " hresp"}, 32'(hresp), 32'h0);
    endtask : rdchk

    function automatic int lv(input int c);
        return (c < 2) ? 1 : c;
    endfunction : lv

    // reference arithmetic kept in plain integers; borrow shows as bit w of the masked difference
    task automatic run_op(input int op);
        int a, t, w, r, res, c, h, vf, sa;
        w = (op == 2 || op == 3) ? 16 : 8;
        a = (w == 16) ? mAcc : mAcc & 'hFF;
        t = (w == 16) ? mTmp : mTmp & 'hFF;
        h = ((a & 15) + (t & 15)) >> 4;
        r = a + t;
        if (op == 1 || op == 3) begin
            h = ((a & 15) < (t & 15)) ? 1 : 0;
            r = (a - t) & ((1 << (w + 1)) - 1);
            t = ~t;
        end
        if (op == 4) r = a << 1;
        if (op == 5) r = (a >> 1) | ((a & 1) << 8);
        res = r & ((1 << w) - 1);
        c = (r >> w) & 1;
        sa = (a >> (w - 1)) & 1;
        vf = (sa == ((t >> (w - 1)) & 1) && ((res >> (w - 1)) & 1) != sa) ? 1 : 0;
        xfer(OFF_EXEC, 1'b1, 32'(op));
        if (op < 6) begin
            mIp = (mIp + 1) & 'hFFFF;
            mAcc = (w == 16) ? res : (mAcc & 'hFF00) | res;
            pMask = (op > 3) ? 'hFFF3 : 'hFFFF;
            if (op > 3) mPsw = (mPsw & 'hFFFE) | c;
            else mPsw = (mPsw & 'hFF70) | (h << 7) | (((res >> (w - 1)) & 1) << 3) | ((res == 0) ? 4 : 0)
                        | (vf << 1) | c;
        end
        rdchk(OFF_ACC, "acc", mAcc);
        rdchk(OFF_PSW, "psw", mPsw, pMask);
        rdchk(OFF_IP, "ip", mIp);
    endtask : run_op

    task setop(input int a, input int t, input int op);
        xfer(OFF_ACC, 1'b1, 32'(a));
        xfer(OFF_TMP, 1'b1, 32'(t));
        mAcc = a;
        mTmp = t;
        run_op(op);
    endtask : setop

    // main sequence
    initial begin
        void'($urandom(46882));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 6; i++) rdchk(8'(4 * i), "reg reset", 32'h0);
        rdchk(OFF_PSW, "psw reset", {16'h0, RST_PSW});
        rdchk(OFF_BANK, "bank reset", 32'h100);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            xfer(8'(4 * i), 1'b1, v);
            rdchk(8'(4 * i), "reg", v & 32'hFFFF);
            if (i == 0) mIp = v & 'hFFFF;
        end
        mPsw = 'h30;
        pMask = 'hFFFF;
        // flag corners first, then random operands and codes
        for (int k = 0; k < 11; k++) setop(tbl[k][0], tbl[k][1], tbl[k][2]);
        setop(16'h5555, 16'h0001, 7);
        for (int k = 0; k < 40; k++) setop($urandom & 'hFFFF, $urandom & 'hFFFF, $urandom_range(0, 5));
        // every enable, mask and request level
        for (int i = 0; i < 32; i++) begin
            xfer(OFF_PSW, 1'b1, 32'(((i >> 4) << 6) | (((i >> 2) & 3) << 4)));
            for (int q = 0; q < 2; q++) begin
                irqRequest <= q[0];
                irqLevel <= i[1:0];
                @(posedge clock);
                @(posedge clock);
                e = (q == 1 && (i >> 4) == 1 && lv(i & 3) < lv((i >> 2) & 3)) ? 1 : 0;
                check("irqAccept", 32'(irqAccept), 32'(e));
            end
        end
        irqRequest <= 1'b0;
        // fill several banks, then read all back to show they do not alias
        for (int b = 0; b < 4; b++) begin
            xfer(OFF_PSW, 1'b1, 32'((banks[b] << 8) | 'h30));
            rdchk(OFF_BANK, "bank base", 32'('h100 + banks[b] * 8));
            for (int s = 0; s < 8; s++) begin
                gpr[banks[b]][s] = $urandom & 'hFF;
                xfer(OFF_GPR_SEL, 1'b1, 32'(s));
                xfer(OFF_GPR_DATA, 1'b1, 32'(gpr[banks[b]][s]));
            end
        end
        for (int b = 0; b < 4; b++) begin
            xfer(OFF_PSW, 1'b1, 32'((banks[b] << 8) | 'h30));
            for (int s = 0; s < 8; s++) begin
                xfer(OFF_GPR_SEL, 1'b1, 32'(s));
                rdchk(OFF_GPR_DATA, "gpr", 32'(gpr[banks[b]][s]));
            end
        end
        // area boundaries of the 64-Kbyte map
        for (int k = 0; k < 8; k++) begin
            e = (areas[k] <= 'h7F) ? 0 : (areas[k] <= 'hFFF) ? 1 : (areas[k] >= 'h8000) ? 2 : 3;
            xfer(OFF_AREA, 1'b1, 32'(areas[k]));
            rdchk(OFF_AREA, "area", 32'((e << 16) | areas[k]));
        end
        // refused places leave state alone and read zero
        xfer(8'h30, 1'b1, 32'hFFFF);
        xfer(8'h05, 1'b1, 32'hFFFF);
        rdchk(8'h30, "unmapped", 32'h0);
        rdchk(8'h05, "misaligned", 32'h0);
        rdchk(OFF_EXEC, "exec read", 32'h0);
        rdchk(OFF_ACC, "acc kept", mAcc);
        // reset in mid-run must drop the enable again
        xfer(OFF_PSW, 1'b1, 32'h0540);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rdchk(OFF_PSW, "psw after reset", 32'h30);
        rdchk(OFF_IP, "ip after reset", 32'h0);
        end_of_test();
    end
endmodule : cpu_register_set_and_flags_tb
